/* File: pkg/tx_space_flag_pkg.sv */
// Shared constants for the transmit FIFO space flag block
package tx_space_flag_pkg;
    localparam int        NUM_CH      = 4;
    localparam int        CH_W        = 2;
    localparam int        SPACE_W     = 10;
    localparam int        WM_W        = 10;
    localparam int        APB_AW      = 8;
    // Register byte offsets
    localparam logic [7:0] CFG_OFS    = 8'h00;
    localparam logic [7:0] LOW_WM_OFS = 8'h10;
    localparam logic [7:0] HIGH_WM_OFS = 8'h20;
    localparam logic [7:0] STAT_OFS   = 8'h30;
    // Config field positions
    localparam int        CFG_LAT_BIT = 0;
    localparam int        CFG_POS_BIT = 1;
    // Reset values
    localparam logic [1:0]      CFG_RST = 2'h2;
    localparam logic [WM_W-1:0] LOW_WM_RST  = 10'h010;
    localparam logic [WM_W-1:0] HIGH_WM_RST = 10'h008;
endpackage

/* File: rtl/pin_sync.sv */
// Two-stage synchroniser for an active-low asynchronous level input
module pin_sync (
    input  wire logic i_clk_sys, // Clock
    input  wire logic i_resetn,  // Async reset, active low
    input  wire logic i_d,       // Asynchronous level
    output logic      o_q        // Synchronised level
);
    logic meta_reg;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            // Idle high, so no false enable is seen after reset
            meta_reg <= 1'b1;
            o_q      <= 1'b1;
        end else begin
            meta_reg <= i_d;
            o_q      <= meta_reg;
        end
    end
endmodule

/* File: rtl/flag_eval.sv */
// Watermark hysteresis evaluation for one FIFO space flag
module flag_eval (
    input  wire logic        i_clk_sys, // Clock
    input  wire logic        i_resetn,  // Async reset, active low
    input  wire logic [9:0]  i_space,   // Free words
    input  wire logic        i_full,    // FIFO full
    input  wire logic [9:0]  i_low_wm,  // Assert threshold
    input  wire logic [9:0]  i_high_wm, // Deassert threshold
    output logic             o_flag     // Space flag
);
    wire do_set = (i_space >= i_low_wm);
    wire do_clr = i_full || (i_space < i_high_wm);
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn)
            o_flag <= 1'b0;
        else if (do_clr)
            o_flag <= 1'b0;
        else if (do_set)
            o_flag <= 1'b1;
    end
endmodule

/* File: rtl/tx_space_flag.sv */
// Transmit FIFO selected and polled space-available flag generator
// Functional notes
// - The polled flag changes only on a rising clock edge.
// - The selected flag is produced only in packet mode, unused in cell mode.
// - The selected flag follows the selected FIFO, not the polled one.
// - The selected flag is high impedance while no transfer is selected.
// - Drive starts three or four cycles after the enable pin falls, per the latency bit; two of those cycles are the synchroniser.
// - The flag asserts when free words reach the low watermark.
// - The flag drops when full or free words fall below the high mark.
// - The deassert watermark comes from a per-channel register.
// - The selected flag changes only on a rising clock edge.
module tx_space_flag
(
    input  wire logic                      i_clk_sys,  // 200 MHz clock
    input  wire logic                      i_resetn,   // Async reset
    input  wire logic                      i_psel,     // APB select
    input  wire logic                      i_penable,  // APB enable
    input  wire logic                      i_pwrite,   // APB write
    input  wire logic [tx_space_flag_pkg::APB_AW-1:0] i_paddr, // APB addr
    input  wire logic [31:0]               i_pwdata,   // APB write data
    output logic      [31:0]               o_prdata,   // APB read data
    output logic                           o_pready,   // APB ready
    output logic                           o_pslverr,  // APB error
    input  wire logic                      i_tx_enb_n, // Transmit enable
    input  wire logic [tx_space_flag_pkg::CH_W-1:0] i_sel_ch, // Sel chan
    input  wire logic [tx_space_flag_pkg::CH_W-1:0] i_poll_ch, // Poll chan
    input  wire logic [tx_space_flag_pkg::NUM_CH*tx_space_flag_pkg::SPACE_W-1:0]
                                           i_fifo_space, // Free words
    input  wire logic [tx_space_flag_pkg::NUM_CH-1:0] i_fifo_full, // Full
    output logic                           o_selected_space_avail,    // Flag
    output logic                           o_selected_space_avail_oe, // OE
    output logic                           o_polled_space_avail       // Flag
);
    import tx_space_flag_pkg::*;

    localparam int CH_WM_STEP = 4;

    logic [1:0]      cfg_reg;
    logic [WM_W-1:0] low_wm_reg  [NUM_CH];
    logic [WM_W-1:0] high_wm_reg [NUM_CH];
    logic            enb_n_sync;
    logic            enb_d1_reg;
    logic            sel_flag_reg;
    logic            poll_flag_reg;

    function automatic logic [SPACE_W-1:0] ch_space(
        input logic [NUM_CH*SPACE_W-1:0] vec,
        input logic [CH_W-1:0]           ch
    );
        ch_space = vec[ch*SPACE_W +: SPACE_W];
    endfunction

    // Enable comes from the link-layer device pin
    pin_sync u_enb_sync (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_tx_enb_n),
        .o_q       (enb_n_sync)
    );

    // APB decode
    wire             apb_acc  = i_psel && i_penable;
    wire             apb_wr   = apb_acc && i_pwrite;
    wire [CH_W-1:0]  wm_ch    = i_paddr[3:2];
    wire             hit_cfg  = (i_paddr == CFG_OFS);
    wire             hit_low  = (i_paddr[7:4] == LOW_WM_OFS[7:4])
                                && (i_paddr[1:0] == 2'h0);
    wire             hit_high = (i_paddr[7:4] == HIGH_WM_OFS[7:4])
                                && (i_paddr[1:0] == 2'h0);
    wire             hit_stat = (i_paddr == STAT_OFS);
    wire             hit_any  = hit_cfg || hit_low || hit_high || hit_stat;
    wire [31:0]      rd_mux   =
        hit_cfg  ? {30'h0, cfg_reg} :
        hit_low  ? {22'h0, low_wm_reg[wm_ch]} :
        hit_high ? {22'h0, high_wm_reg[wm_ch]} :
        hit_stat ? {29'h0, !enb_n_sync, poll_flag_reg, sel_flag_reg} :
                   32'h0;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn)
            cfg_reg <= CFG_RST;
        else if (apb_wr && hit_cfg)
            cfg_reg <= i_pwdata[1:0];
    end

    // Per-channel watermark registers
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                low_wm_reg[i]  <= LOW_WM_RST;
                high_wm_reg[i] <= HIGH_WM_RST;
            end
        end else if (apb_wr && hit_low) begin
            low_wm_reg[wm_ch] <= i_pwdata[WM_W-1:0];
        end else if (apb_wr && hit_high) begin
            high_wm_reg[wm_ch] <= i_pwdata[WM_W-1:0];
        end
    end

    // Zero-wait APB answers in the access cycle
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0;
        end else begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !hit_any;
            o_prdata  <= (i_psel && !i_penable) ? rd_mux : 32'h0;
        end
    end

    // Flag evaluation, selected channel independent of polled channel
    wire sel_eval;
    wire poll_eval;
    flag_eval u_sel_eval (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_space   (ch_space(i_fifo_space, i_sel_ch)),
        .i_full    (i_fifo_full[i_sel_ch]),
        .i_low_wm  (low_wm_reg[i_sel_ch]),
        .i_high_wm (high_wm_reg[i_sel_ch]),
        .o_flag    (sel_eval)
    );
    flag_eval u_poll_eval (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_space   (ch_space(i_fifo_space, i_poll_ch)),
        .i_full    (i_fifo_full[i_poll_ch]),
        .i_low_wm  (low_wm_reg[i_poll_ch]),
        .i_high_wm (high_wm_reg[i_poll_ch]),
        .o_flag    (poll_eval)
    );

    wire pos_mode  = cfg_reg[CFG_POS_BIT];
    wire lat_two   = cfg_reg[CFG_LAT_BIT];
    wire enb_act   = !enb_n_sync;
    // One cycle after enable for latency 0, two for latency 1
    wire drive_nxt = pos_mode && enb_act
                     && (lat_two ? enb_d1_reg : 1'b1);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            enb_d1_reg <= 1'b0;
        end else begin
            enb_d1_reg <= enb_act;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_selected_space_avail_oe <= 1'b0;
            o_selected_space_avail    <= 1'b0;
            o_polled_space_avail      <= 1'b0;
            sel_flag_reg              <= 1'b0;
            poll_flag_reg             <= 1'b0;
        end else begin
            o_selected_space_avail_oe <= drive_nxt;
            o_selected_space_avail    <= drive_nxt && sel_eval;
            o_polled_space_avail      <= poll_eval;
            sel_flag_reg              <= sel_eval;
            poll_flag_reg             <= poll_eval;
        end
    end

    // Free words of the selected and polled channels, for the checks below
    wire [SPACE_W-1:0] sel_space  = ch_space(i_fifo_space, i_sel_ch);
    wire [SPACE_W-1:0] poll_space = ch_space(i_fifo_space, i_poll_ch);

    property p_oe_off_when_idle;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !enb_act |=> !o_selected_space_avail_oe;
    endproperty
    a_oe_off_when_idle: assert property (p_oe_off_when_idle)
        else $error("selected flag driven while not selected");

    property p_cell_mode_off;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !pos_mode |=> !o_selected_space_avail_oe;
    endproperty
    a_cell_mode_off: assert property (p_cell_mode_off)
        else $error("selected flag driven in cell mode");

    property p_lat_one;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (pos_mode && !lat_two && $rose(enb_act))
            |=> o_selected_space_avail_oe;
    endproperty
    a_lat_one: assert property (p_lat_one)
        else $error("selected flag not driven after one cycle");

    property p_lat_two;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (pos_mode && lat_two && $rose(enb_act) && $stable(cfg_reg))
            |=> !o_selected_space_avail_oe ##1
                (o_selected_space_avail_oe || !enb_act);
    endproperty
    a_lat_two: assert property (p_lat_two)
        else $error("selected flag drive timing wrong for latency two");

    property p_full_clears;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        i_fifo_full[i_sel_ch] |=> !sel_eval;
    endproperty
    a_full_clears: assert property (p_full_clears)
        else $error("selected flag set while FIFO full");

    property p_set_on_space;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (ch_space(i_fifo_space, i_sel_ch) >= low_wm_reg[i_sel_ch]
         && ch_space(i_fifo_space, i_sel_ch) >= high_wm_reg[i_sel_ch]
         && !i_fifo_full[i_sel_ch]) |=> sel_eval;
    endproperty
    a_set_on_space: assert property (p_set_on_space)
        else $error("selected flag not set above low watermark");

    property p_below_high;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (ch_space(i_fifo_space, i_sel_ch) < high_wm_reg[i_sel_ch])
            |=> !sel_eval;
    endproperty
    a_below_high: assert property (p_below_high)
        else $error("selected flag set below high watermark");

    property p_sel_follows;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_selected_space_avail_oe |-> o_selected_space_avail
            == $past(sel_eval);
    endproperty
    a_sel_follows: assert property (p_sel_follows)
        else $error("selected flag does not track selected FIFO");

    property p_poll_follows;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        ##1 o_polled_space_avail == $past(poll_eval);
    endproperty
    a_poll_follows: assert property (p_poll_follows)
        else $error("polled flag does not track polled FIFO");

    property p_oe_stands;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (pos_mode && enb_act && $past(enb_act))
            |=> o_selected_space_avail_oe;
    endproperty
    a_oe_stands: assert property (p_oe_stands)
        else $error("selected flag drive dropped while selected");

    property p_flag_needs_oe;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_selected_space_avail |-> o_selected_space_avail_oe;
    endproperty
    a_flag_needs_oe: assert property (p_flag_needs_oe)
        else $error("selected flag high while not driven");

    property p_flag_idle_low;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !enb_act |=> !o_selected_space_avail;
    endproperty
    a_flag_idle_low: assert property (p_flag_idle_low)
        else $error("selected flag high while not selected");

    property p_cell_no_flag;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !pos_mode |=> !o_selected_space_avail;
    endproperty
    a_cell_no_flag: assert property (p_cell_no_flag)
        else $error("selected flag high in cell mode");

    property p_full_drops_flag;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        i_fifo_full[i_sel_ch] |=> ##1 !o_selected_space_avail;
    endproperty
    a_full_drops_flag: assert property (p_full_drops_flag)
        else $error("selected flag shown high for a full FIFO");

    property p_space_raises_flag;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (sel_space >= low_wm_reg[i_sel_ch]
         && sel_space >= high_wm_reg[i_sel_ch]
         && !i_fifo_full[i_sel_ch])
            |=> ##1 (o_selected_space_avail || !o_selected_space_avail_oe);
    endproperty
    a_space_raises_flag: assert property (p_space_raises_flag)
        else $error("selected flag not shown above low watermark");

    property p_low_space_drops;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (sel_space < high_wm_reg[i_sel_ch]) |=> ##1 !o_selected_space_avail;
    endproperty
    a_low_space_drops: assert property (p_low_space_drops)
        else $error("selected flag shown high below high watermark");

    property p_poll_full_low;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        i_fifo_full[i_poll_ch] |=> ##1 !o_polled_space_avail;
    endproperty
    a_poll_full_low: assert property (p_poll_full_low)
        else $error("polled flag shown high for a full FIFO");

    property p_poll_space_high;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (poll_space >= low_wm_reg[i_poll_ch]
         && poll_space >= high_wm_reg[i_poll_ch]
         && !i_fifo_full[i_poll_ch]) |=> ##1 o_polled_space_avail;
    endproperty
    a_poll_space_high: assert property (p_poll_space_high)
        else $error("polled flag not shown above low watermark");
endmodule

/* File: dv/link_layer_model.sv */
// Link-layer partner that opens and closes selected transfers
module link_layer_model (
    input  wire logic       i_clk_sys,  // Clock
    input  wire logic       i_oe,       // Selected flag drive enable
    output logic            o_tx_enb_n, // Transfer enable, active low
    output logic [1:0]      o_sel_ch    // Selected channel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_tx_enb_n = 1'b1;
        o_sel_ch   = 2'h0;
    end
    // Counts edges until drive is seen; oe shows one edge after it is set
    task automatic open_xfer(input logic [1:0] ch, output int edges);
        edges = 0;
        @(posedge i_clk_sys);
        o_tx_enb_n <= 1'b0;
        o_sel_ch   <= ch;
        do begin
            @(posedge i_clk_sys);
            edges++;
        end while (i_oe !== 1'b1 && edges < 8);
    endtask
    task automatic close_xfer();
        @(posedge i_clk_sys);
        o_tx_enb_n <= 1'b1;
    endtask
    // Called right after an edge by the bench
    task automatic set_ch(input logic [1:0] ch);
        o_sel_ch <= ch;
    endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the transmit space flag block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tx_space_flag_pkg::*;
    typedef struct {
        logic [1:0] s, p;
        logic [9:0] a, b;
        logic       f, es, ep;
    } row_t;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd, prdata;
    logic        err, pready, pslverr, enb_n, flag, oe, pflag;
    logic [1:0]  sel_ch;
    logic [1:0]  poll_ch = 2'h0;
    logic [39:0] space = 40'h0;
    logic [39:0] v;
    logic [3:0]  full = 4'h0;
    int          errors = 0;
    int          comparisons = 0;
    int          edges;
    row_t        rows[9];
    always #2.5 clk = ~clk;
    tx_space_flag uut (.i_clk_sys(clk), .i_resetn(resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_tx_enb_n(enb_n), .i_sel_ch(sel_ch),
        .i_poll_ch(poll_ch), .i_fifo_space(space), .i_fifo_full(full),
        .o_selected_space_avail(flag), .o_selected_space_avail_oe(oe),
        .o_polled_space_avail(pflag));
    link_layer_model llm (.i_clk_sys(clk), .i_oe(oe), .o_tx_enb_n(enb_n),
        .o_sel_ch(sel_ch));
    task automatic check(input string name, input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        check("pready", {31'h0, pready}, 32'h1);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #50000;
        errors++;
        print_verdict();
    end
    initial begin
        rows[0] = '{2'h0, 2'h1, 10'h020, 10'h000, 1'b0, 1'b1, 1'b0};
        rows[1] = '{2'h0, 2'h1, 10'h00c, 10'h00c, 1'b0, 1'b1, 1'b0};
        rows[2] = '{2'h0, 2'h1, 10'h004, 10'h010, 1'b0, 1'b0, 1'b1};
        rows[3] = '{2'h0, 2'h1, 10'h00f, 10'h008, 1'b0, 1'b0, 1'b1};
        rows[4] = '{2'h0, 2'h1, 10'h020, 10'h007, 1'b1, 1'b0, 1'b0};
        rows[5] = '{2'h2, 2'h2, 10'h014, 10'h014, 1'b0, 1'b0, 1'b0};
        rows[6] = '{2'h2, 2'h2, 10'h018, 10'h018, 1'b0, 1'b1, 1'b1};
        rows[7] = '{2'h2, 2'h2, 10'h00c, 10'h00c, 1'b0, 1'b1, 1'b1};
        rows[8] = '{2'h2, 2'h2, 10'h00b, 10'h00b, 1'b0, 1'b0, 1'b0};
        repeat (5) @(posedge clk);
        check("oe in reset", {31'h0, oe}, 32'h0);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        check("oe after release", {31'h0, oe}, 32'h0);
        check("poll after release", {31'h0, pflag}, 32'h0);
        apb(1'b0, CFG_OFS, 32'h0);
        check("cfg reset", rd, {30'h0, CFG_RST});
        check("cfg no error", {31'h0, err}, 32'h0);
        apb(1'b0, LOW_WM_OFS, 32'h0);
        check("low wm reset", rd, {22'h0, LOW_WM_RST});
        apb(1'b0, HIGH_WM_OFS + 8'h0c, 32'h0);
        check("high wm reset", rd, {22'h0, HIGH_WM_RST});
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        // Channel 2 gets its own marks, so its rows differ from the others
        apb(1'b1, LOW_WM_OFS + 8'h08, 32'h18);
        apb(1'b1, HIGH_WM_OFS + 8'h08, 32'h0c);
        apb(1'b0, HIGH_WM_OFS + 8'h08, 32'h0);
        check("ch2 high wm", rd, 32'h0c);
        apb(1'b1, CFG_OFS, 32'h0);
        llm.open_xfer(2'h0, edges);
        check("cell mode oe", {31'h0, oe}, 32'h0);
        llm.close_xfer();
        for (int lat = 1; lat >= 0; lat--) begin
            apb(1'b1, CFG_OFS, 32'h2 | 32'(lat));
            llm.open_xfer(2'h0, edges);
            check("drive latency", 32'(edges), 32'(4 + lat));
            if (lat == 1) begin
                llm.close_xfer();
                repeat (5) @(posedge clk);
                check("oe released", {31'h0, oe}, 32'h0);
            end
        end
        foreach (rows[i]) begin
            @(posedge clk);
            v = 40'h0;
            v[rows[i].p * 10 +: 10] = rows[i].b;
            v[rows[i].s * 10 +: 10] = rows[i].a;
            space   <= v;
            full    <= 4'(rows[i].f) << rows[i].s;
            poll_ch <= rows[i].p;
            llm.set_ch(rows[i].s);
            repeat (4) @(posedge clk);
            check("oe", {31'h0, oe}, 32'h1);
            check("sel flag", {31'h0, flag}, {31'h0, rows[i].es});
            check("poll flag", {31'h0, pflag}, {31'h0, rows[i].ep});
        end
        apb(1'b0, STAT_OFS, 32'h0);
        check("status", rd, 32'h4);
        // Reset in mid-transfer: drive stops at once, resumes after sync
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        check("oe mid reset", {31'h0, oe}, 32'h0);
        resetn <= 1'b1;
        apb(1'b0, LOW_WM_OFS + 8'h08, 32'h0);
        check("ch2 low wm reset", rd, {22'h0, LOW_WM_RST});
        apb(1'b0, HIGH_WM_OFS + 8'h08, 32'h0);
        check("ch2 high wm reset", rd, {22'h0, HIGH_WM_RST});
        check("oe after reset", {31'h0, oe}, 32'h1);
        llm.close_xfer();
        repeat (5) @(posedge clk);
        check("oe end", {31'h0, oe}, 32'h0);
        print_verdict();
    end
endmodule
